/* File: bench/pdrc_props.sv */
// Concurrent checks on the power-down and reset control ports
`default_nettype none
module pdrc_props #(
   parameter NREG = 12
) (
   input wire logic REF_CLK,
   input wire logic SRST,
   input wire logic CP_EVENT,
   input wire logic REG_WR,
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic CHIP_SLEEP,
   input wire logic HARD_RESET_ACTIVE,
   input wire logic SOFT_RESET_ACTIVE,
   input wire logic PLL_PD,
   input wire logic DIST_PD,
   input wire logic [2:0] HS_PD_EN,
   input wire logic [2:0] HS_PROTECT,
   input wire logic [4:0] FINE_DELAY,
   input wire logic [2:0] RAMP_CODE,
   input wire logic [10:0] RAMP_CURRENT_UA
);
   default clocking @(posedge REF_CLK);
   endclocking
   default disable iff (SRST);
   ////////////////////////////////////////////////////////////
   // A write only counts while neither reset holds the registers
   wire ok = REG_WR && !HARD_RESET_ACTIVE && !SOFT_RESET_ACTIVE;
   logic clr_wr;
   // Remembers a write that clears the soft-reset bit
   always @(posedge REF_CLK) begin
      clr_wr <= REG_WR && REG_ADDR == 8'h00 && !REG_WDATA[5];
   end
   // Synchronous power-down request, then two quiet cycles
   sequence s_sync_req;
      ok && REG_ADDR == 8'h0A && REG_WDATA[1:0] == 2'h3 && !PLL_PD && !CHIP_SLEEP && !CP_EVENT;
   endsequence
   sequence s_quiet;
      (!CP_EVENT && !REG_WR && !CHIP_SLEEP)[*2];
   endsequence
   ////////////////////////////////////////////////////////////
   a_pll_async: assert property (ok && REG_ADDR == 8'h0A && REG_WDATA[1:0] == 2'h1 |-> ##2 PLL_PD)
      else $error("PLL not down after async code");
   a_sync_wait: assert property (s_sync_req ##1 s_quiet |-> !PLL_PD)
      else $error("PLL down before pump event");
   a_sync_go: assert property (s_sync_req ##1 s_quiet ##1 CP_EVENT |=> PLL_PD)
      else $error("PLL not down after pump event");
   a_dist_follow: assert property (ok && REG_ADDR == 8'h58 |-> ##2 DIST_PD == $past(REG_WDATA[3], 2))
      else $error("Distribution power-down wrong");
   a_fine_follow: assert property (ok && REG_ADDR == 8'h36 |-> ##2 FINE_DELAY == $past(REG_WDATA[5:1], 2))
      else $error("Fine delay field wrong");
   a_ramp_calc: assert property (RAMP_CURRENT_UA == 11'h0C8 * (11'h001 + RAMP_CODE))
      else $error("Ramp current wrong");
   a_sleep_state: assert property (CHIP_SLEEP && $past(CHIP_SLEEP) |-> PLL_PD && &HS_PD_EN && &HS_PROTECT)
      else $error("Sleep state outputs wrong");
   a_soft_enter: assert property (REG_WR && !HARD_RESET_ACTIVE && REG_ADDR == 8'h00 && REG_WDATA[5]
      |-> ##2 SOFT_RESET_ACTIVE[*3])
      else $error("Soft reset not held");
   a_soft_sticky: assert property ($fell(SOFT_RESET_ACTIVE) |-> HARD_RESET_ACTIVE || $past(clr_wr))
      else $error("Soft reset ended by itself");
endmodule // pdrc_props
bind pdrc_top pdrc_props #(.NREG(NREG)) u_pdrc_props (.REF_CLK(REF_CLK), .SRST(SRST), .CP_EVENT(CP_EVENT),
   .REG_WR(REG_WR), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .CHIP_SLEEP(CHIP_SLEEP),
   .HARD_RESET_ACTIVE(HARD_RESET_ACTIVE), .SOFT_RESET_ACTIVE(SOFT_RESET_ACTIVE), .PLL_PD(PLL_PD),
   .DIST_PD(DIST_PD), .HS_PD_EN(HS_PD_EN), .HS_PROTECT(HS_PROTECT), .FINE_DELAY(FINE_DELAY),
   .RAMP_CODE(RAMP_CODE), .RAMP_CURRENT_UA(RAMP_CURRENT_UA));
`default_nettype wire

/* File: bench/tb_pdrc_top.sv */
// Self-checking bench of the power-down and reset control
`default_nettype none
module tb_pdrc_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, srst = 1, pin = 1, cp = 0, wr_en = 0;
   logic [7:0] addr = 8'h00, wdata = 8'h00;
   wire [7:0] rdata;
   wire slp, hra, sra, pll, c_off, dpd, syh;
   wire [2:0] hs_en, hs_pr, rcode, caps, bpd;
   wire [1:0] spd, scm;
   wire [4:0] fine;
   wire [10:0] ua;
   logic [15:0] o [17];
   logic [20:0] q [$];
   logic [7:0] dv [256];
   logic [7:0] ad [10] = '{8'h00, 8'h0A, 8'h35, 8'h36, 8'h3D, 8'h3E, 8'h3F, 8'h40, 8'h41, 8'h42};
   int n_fail = 0, n_checks = 0, cyc = 0;
   ////////////////////////////////////////////////////////////
   // Device under test, every input driven here
   pdrc_top DUT (.REF_CLK(clk), .SRST(srst), .FUNC_PIN(pin), .CP_EVENT(cp), .REG_WR(wr_en), .REG_ADDR(addr),
      .REG_WDATA(wdata), .REG_RDATA(rdata), .CHIP_SLEEP(slp), .HARD_RESET_ACTIVE(hra), .SOFT_RESET_ACTIVE(sra),
      .PLL_PD(pll), .CLOCKS_OFF(c_off), .DIST_PD(dpd), .SYNC_HOLD(syh), .HS_PD_EN(hs_en), .HS_PROTECT(hs_pr),
      .SEC_PD(spd), .SEC_CMOS(scm), .FINE_DELAY(fine), .RAMP_CODE(rcode), .CAP_SELECT(caps),
      .RAMP_CURRENT_UA(ua), .BLOCK_PD(bpd));
   // Output fields by index, for the monitor
   always_comb o = '{16'(rdata), 16'(slp), 16'(hra), 16'(sra), 16'(pll), 16'(c_off), 16'(dpd), 16'(syh),
      16'(hs_en), 16'(hs_pr), 16'(spd), 16'(scm), 16'(fine), 16'(rcode), 16'(caps), 16'(ua), 16'(bpd)};
   initial forever #10 clk = ~clk;
   // Hang guard, far above the roughly 160 cycles needed
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_fail++;
         report_and_stop();
      end
   end
   // Monitor: settled after the falling edge, checks every queued note, oldest first
   always @(negedge clk) begin
      #1;
      while (q.size() > 0) begin
         logic [20:0] e;
         e = q.pop_front();
         n_checks++;
         if (o[e[20:16]] !== e[15:0]) begin
            n_fail++;
            $display("[ERR] %0t field %0d got %h exp %h", $time, e[20:16], o[e[20:16]], e[15:0]);
         end
      end
   end
   ////////////////////////////////////////////////////////////
   task automatic note(input int f, input logic [15:0] v);
      q.push_back({f[4:0], v});
   endtask
   task automatic idle(input int n);
      wr_en = 0;
      repeat (n) @(negedge clk);
   endtask
   // Holds the strobe; the caller lowers it through idle or rd
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      wr_en = 1;
      addr = a;
      wdata = v;
      @(negedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] v);
      wr_en = 0;
      addr = a;
      repeat (2) @(negedge clk);
      note(0, 16'(v));
   endtask
   task automatic pump();
      cp = 1;
      @(negedge clk);
      cp = 0;
      @(negedge clk);
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(35));
      repeat (10) @(negedge clk);
      srst = 0;
      idle(5);
      note(2, 1'h0);
      note(15, 16'h00C8);
      foreach (ad[i]) rd(ad[i], 8'h00);
      // Random contents; soft-reset bit kept clear
      foreach (ad[i]) begin
         dv[ad[i]] = 8'($urandom) & (ad[i] == 8'h00 ? 8'hDF : 8'hFF);
         wr(ad[i], dv[ad[i]]);
      end
      foreach (ad[i]) rd(ad[i], dv[ad[i]]);
      note(4, 16'(dv[10][1:0] == 2'h1));
      note(8, 16'({dv[63][1], dv[62][1], dv[61][1]}));
      note(9, 16'({dv[63][1:0] == 2'h2, dv[62][1:0] == 2'h2, dv[61][1:0] == 2'h2}));
      note(10, 16'({dv[65][0], dv[64][0]}));
      note(11, 16'({dv[65][2], dv[64][2]}));
      note(12, 16'(dv[54][5:1]));
      note(13, 16'(dv[53][2:0]));
      note(14, 16'(dv[53][5:3]));
      note(15, 16'(11'h0C8 * (11'h001 + dv[53][2:0])));
      note(16, 16'(dv[66][2:0]));
      wr(8'h20, 8'h5A);
      rd(8'h20, 8'h00);
      for (int c = 0; c < 4; c++) begin
         wr(8'h0A, 8'(c));
         idle(2);
         note(4, 16'(c == 1));
      end
      pump();
      note(4, 1'h1);
      wr(8'h0A, 8'h00);
      idle(1);
      pump();
      wr(8'h3D, 8'h00);
      wr(8'h3E, 8'h02);
      wr(8'h3F, 8'h03);
      wr(8'h58, 8'h08);
      idle(2);
      note(6, 1'h1);
      note(9, 16'h0003);
      wr(8'h58, 8'h20);
      idle(1);
      pin = 0;
      idle(5);
      note(6, 1'h0);
      note(7, 1'h1);
      pin = 1;
      idle(5);
      note(7, 1'h0);
      // Sleep: port stays live, writes land during sleep
      wr(8'h58, 8'h40);
      wr(8'h35, 8'h15);
      idle(1);
      pin = 0;
      idle(5);
      note(1, 1'h1);
      note(5, 1'h1);
      note(10, 16'h0003);
      wr(8'h36, 8'h3E);
      rd(8'h36, 8'h3E);
      pin = 1;
      idle(5);
      note(1, 1'h0);
      note(4, 1'h0);
      note(12, 16'h001F);
      // Controller aligns outputs after wake with a soft sync pulse
      wr(8'h58, 8'h44);
      idle(2);
      note(7, 1'h1);
      wr(8'h58, 8'h40);
      idle(2);
      note(7, 1'h0);
      rd(8'h35, 8'h15);
      wr(8'h00, 8'h20);
      idle(3);
      note(3, 1'h1);
      wr(8'h36, 8'h0A);
      rd(8'h36, 8'h00);
      rd(8'h00, 8'h20);
      wr(8'h00, 8'h00);
      idle(3);
      note(3, 1'h0);
      wr(8'h35, 8'h2D);
      idle(1);
      pin = 0;
      idle(2);
      note(2, 1'h1);
      wr(8'h35, 8'h11);
      idle(1);
      pin = 1;
      idle(5);
      note(2, 1'h0);
      rd(8'h35, 8'h00);
      idle(2);
      report_and_stop();
   end
endmodule // tb_pdrc_top
`default_nettype wire

/* File: rtl/pdrc_map.vh */
// Register offsets, field positions, reset values and mode codes of the power-down and reset control
`ifndef PDRC_MAP_VH
`define PDRC_MAP_VH
// Register addresses
`define PDRC_ADDR_PORT_CFG 8'h00
`define PDRC_ADDR_PLL_PD 8'h0A
`define PDRC_ADDR_DLY_FS 8'h35
`define PDRC_ADDR_DLY_FINE 8'h36
`define PDRC_ADDR_FUNC_SYNC 8'h58
`define PDRC_ADDR_OUT_PD0 8'h3D
`define PDRC_ADDR_OUT_PD1 8'h3E
`define PDRC_ADDR_OUT_PD2 8'h3F
`define PDRC_ADDR_OUT_PD3 8'h40
`define PDRC_ADDR_OUT_PD4 8'h41
`define PDRC_ADDR_BLOCK_PD 8'h42
// Reset values
`define PDRC_RST_PORT_CFG 8'h00
`define PDRC_RST_PLL_PD 8'h00
`define PDRC_RST_DLY_FS 8'h00
`define PDRC_RST_DLY_FINE 8'h00
`define PDRC_RST_FUNC_SYNC 8'h00
`define PDRC_RST_OUT_PD 8'h00
`define PDRC_RST_BLOCK_PD 8'h00
// Field positions
`define PDRC_BIT_SOFT_RESET 5
`define PDRC_BIT_DIST_PD 3
`define PDRC_BIT_SOFT_SYNC 2
`define PDRC_FUNC_HI 6
`define PDRC_FUNC_LO 5
`define PDRC_FINE_HI 5
`define PDRC_FINE_LO 1
`define PDRC_RAMP_HI 2
`define PDRC_RAMP_LO 0
`define PDRC_CAPS_HI 5
`define PDRC_CAPS_LO 3
`define PDRC_OUT_FMT_BIT 2
// Multipurpose pin functions
`define PDRC_FUNC_HARD_RESET 2'h0
`define PDRC_FUNC_SYNC 2'h1
`define PDRC_FUNC_SLEEP 2'h2
// PLL power-down codes
`define PDRC_PLL_ASYNC_PD 2'h1
`define PDRC_PLL_SYNC_PD 2'h3
// High-swing output power-down codes
`define PDRC_HS_PD_PROT 2'h2
`define PDRC_HS_PD_NOPROT 2'h3
// Ramp current step in microamps
`define PDRC_RAMP_STEP_UA 11'h0C8
`endif

/* File: rtl/pdrc_regfile.v */
// Register storage for the power-down and reset control with selective default restore
`default_nettype none
`include "pdrc_map.vh"
module pdrc_regfile #(
   parameter NREG = 12
) (
   input wire clk,
   input wire hard_rst,
   input wire soft_rst,
   input wire wr_en,
   input wire [3:0] wr_idx,
   input wire [7:0] wr_data,
   input wire [3:0] rd_idx,
   output reg [7:0] rd_data,
   output wire [8*NREG-1:0] flat
);
   reg [7:0] mem [0:NREG-1];
   integer i;

   // Default value per register index
   function [7:0] pdrc_default;
      input [3:0] idx;
      begin
         case (idx)
            4'h0: pdrc_default = `PDRC_RST_PORT_CFG;
            4'h1: pdrc_default = `PDRC_RST_PLL_PD;
            4'h2: pdrc_default = `PDRC_RST_DLY_FS;
            4'h3: pdrc_default = `PDRC_RST_DLY_FINE;
            4'h4: pdrc_default = `PDRC_RST_FUNC_SYNC;
            4'hA: pdrc_default = `PDRC_RST_BLOCK_PD;
            default: pdrc_default = `PDRC_RST_OUT_PD;
         endcase
      end
   endfunction

   // Hard reset clears all; soft reset spares index 0 (port config)
   always @(posedge clk) begin
      for (i = 0; i < NREG; i = i + 1) begin
         if (hard_rst || (soft_rst && i != 0)) begin
            mem[i] <= pdrc_default(i[3:0]);
         end else if (wr_en && wr_idx == i[3:0]) begin
            mem[i] <= wr_data;
         end
      end
   end

   // Registered read data
   always @(posedge clk) begin
      if (rd_idx < NREG) begin
         rd_data <= mem[rd_idx];
      end else begin
         rd_data <= 8'h00;
      end
   end

   genvar g;
   generate
      for (g = 0; g < NREG; g = g + 1) begin : g_flat
         assign flat[8*g+7:8*g] = mem[g];
      end
   endgenerate
endmodule // pdrc_regfile
`default_nettype wire

/* File: rtl/pdrc_sync2.v */
// Two-stage synchroniser for an asynchronous level
`default_nettype none
module pdrc_sync2 #(
   parameter RST_VAL = 1'b1
) (
   input wire clk,
   input wire srst,
   input wire d,
   output reg q
);
   reg meta;

   // First stage feeds only the second
   always @(posedge clk) begin
      if (srst) begin
         meta <= RST_VAL;
         q <= RST_VAL;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule // pdrc_sync2
`default_nettype wire

/* File: rtl/pdrc_top.v */
// Power-down, sleep and reset control of the clock distribution device
`default_nettype none
`include "pdrc_map.vh"
module pdrc_top #(
   parameter NREG = 12
) (
   input wire REF_CLK,
   input wire SRST,
   input wire FUNC_PIN,
   input wire CP_EVENT,
   input wire REG_WR,
   input wire [7:0] REG_ADDR,
   input wire [7:0] REG_WDATA,
   output wire [7:0] REG_RDATA,
   output reg CHIP_SLEEP,
   output reg HARD_RESET_ACTIVE,
   output reg SOFT_RESET_ACTIVE,
   output reg PLL_PD,
   output reg CLOCKS_OFF,
   output reg DIST_PD,
   output reg SYNC_HOLD,
   output reg [2:0] HS_PD_EN,
   output reg [2:0] HS_PROTECT,
   output reg [1:0] SEC_PD,
   output reg [1:0] SEC_CMOS,
   output reg [4:0] FINE_DELAY,
   output reg [2:0] RAMP_CODE,
   output reg [2:0] CAP_SELECT,
   output reg [10:0] RAMP_CURRENT_UA,
   output reg [2:0] BLOCK_PD
);
   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisation and function decode
   wire pin_sync;
   wire [8*NREG-1:0] regs;
   wire [7:0] r_port = regs[7:0];
   wire [7:0] r_pll = regs[15:8];
   wire [7:0] r_fs = regs[23:16];
   wire [7:0] r_fine = regs[31:24];
   wire [7:0] r_func = regs[39:32];
   wire [7:0] r_blk = regs[87:80];
   wire [1:0] func_sel = r_func[`PDRC_FUNC_HI:`PDRC_FUNC_LO];
   reg [3:0] wr_idx;
   reg [3:0] rd_idx;
   reg addr_hit;
   reg [4:0] dec_code;
   reg pll_pd_pending;
   reg [1:0] pll_mode_prev;
   reg hard_seen;
   integer k;
   // Full default byte, only the mode field is kept for the previous-mode tracker
   localparam [7:0] PLL_RST = `PDRC_RST_PLL_PD;

   pdrc_sync2 #(.RST_VAL(1'b1)) u_pin_sync (
      .clk(REF_CLK),
      .srst(SRST),
      .d(FUNC_PIN),
      .q(pin_sync)
   );

   // Hard reset: raw low pin forces reset at once, release follows the synchronised level
   wire hard_raw = (func_sel == `PDRC_FUNC_HARD_RESET) && !FUNC_PIN;
   wire hard_rst_int = SRST || hard_raw || hard_seen;
   wire soft_rst_int = r_port[`PDRC_BIT_SOFT_RESET];

   // Hard reset is held until the synchronised pin reads high again
   always @(posedge REF_CLK) begin
      if (SRST) begin
         hard_seen <= 1'b0;
      end else if (hard_raw) begin
         hard_seen <= 1'b1;
      end else if (pin_sync) begin
         hard_seen <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Address decode; unmapped addresses drop writes and read zero
   function [4:0] pdrc_decode;
      input [7:0] a;
      begin
         case (a)
            `PDRC_ADDR_PORT_CFG: pdrc_decode = 5'h10;
            `PDRC_ADDR_PLL_PD: pdrc_decode = 5'h11;
            `PDRC_ADDR_DLY_FS: pdrc_decode = 5'h12;
            `PDRC_ADDR_DLY_FINE: pdrc_decode = 5'h13;
            `PDRC_ADDR_FUNC_SYNC: pdrc_decode = 5'h14;
            `PDRC_ADDR_OUT_PD0: pdrc_decode = 5'h15;
            `PDRC_ADDR_OUT_PD1: pdrc_decode = 5'h16;
            `PDRC_ADDR_OUT_PD2: pdrc_decode = 5'h17;
            `PDRC_ADDR_OUT_PD3: pdrc_decode = 5'h18;
            `PDRC_ADDR_OUT_PD4: pdrc_decode = 5'h19;
            `PDRC_ADDR_BLOCK_PD: pdrc_decode = 5'h1A;
            default: pdrc_decode = 5'h0B;
         endcase
      end
   endfunction

   // Index and hit flag from the decoded address
   always @* begin
      dec_code = pdrc_decode(REG_ADDR);
      addr_hit = dec_code >= 5'h10;
      wr_idx = dec_code[3:0]; // Low nibble is the register index
      rd_idx = addr_hit ? wr_idx : 4'hF;
   end

   // Writes stay open in sleep; settings take effect at once unless sleep forces the output (PLL, high-swing, secondary power-down)
   pdrc_regfile #(.NREG(NREG)) u_regs (
      .clk(REF_CLK),
      .hard_rst(hard_rst_int),
      .soft_rst(soft_rst_int),
      .wr_en(REG_WR && addr_hit && !hard_rst_int),
      .wr_idx(wr_idx),
      .wr_data(REG_WDATA),
      .rd_idx(rd_idx),
      .rd_data(REG_RDATA),
      .flat(regs)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Synchronous PLL power-down waits for a charge-pump event
   always @(posedge REF_CLK) begin
      if (hard_rst_int || soft_rst_int) begin
         pll_pd_pending <= 1'b0;
         pll_mode_prev <= PLL_RST[1:0];
         PLL_PD <= 1'b0;
      end else begin
         pll_mode_prev <= r_pll[1:0];
         if (CHIP_SLEEP || r_pll[1:0] == `PDRC_PLL_ASYNC_PD) begin
            PLL_PD <= 1'b1;
            pll_pd_pending <= 1'b0;
         end else if (r_pll[1:0] == `PDRC_PLL_SYNC_PD) begin
            if (CP_EVENT && (pll_pd_pending || pll_mode_prev != `PDRC_PLL_SYNC_PD || PLL_PD)) begin
               PLL_PD <= 1'b1;
               pll_pd_pending <= 1'b0;
            end else if (!PLL_PD) begin
               pll_pd_pending <= 1'b1;
            end
         end else begin
            PLL_PD <= 1'b0;
            pll_pd_pending <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sleep, sync and output power state
   always @(posedge REF_CLK) begin
      if (SRST) begin
         CHIP_SLEEP <= 1'b0;
         HARD_RESET_ACTIVE <= 1'b1;
         SOFT_RESET_ACTIVE <= 1'b0;
         CLOCKS_OFF <= 1'b1;
         DIST_PD <= 1'b0;
         SYNC_HOLD <= 1'b0;
         HS_PD_EN <= 3'h0;
         HS_PROTECT <= 3'h0;
         SEC_PD <= 2'h0;
         SEC_CMOS <= 2'h0;
         FINE_DELAY <= 5'h00;
         RAMP_CODE <= 3'h0;
         CAP_SELECT <= 3'h0;
         RAMP_CURRENT_UA <= 11'h0C8;
         BLOCK_PD <= 3'h0;
      end else begin
         HARD_RESET_ACTIVE <= hard_rst_int;
         SOFT_RESET_ACTIVE <= soft_rst_int;
         CHIP_SLEEP <= (func_sel == `PDRC_FUNC_SLEEP) && !pin_sync;
         CLOCKS_OFF <= ((func_sel == `PDRC_FUNC_SLEEP) && !pin_sync) || hard_rst_int || soft_rst_int;
         DIST_PD <= r_func[`PDRC_BIT_DIST_PD];
         // Pin low with the sync function selected, or the soft-sync bit, holds outputs in a known state
         SYNC_HOLD <= ((func_sel == `PDRC_FUNC_SYNC) && !pin_sync) || r_func[`PDRC_BIT_SOFT_SYNC];
         // High-swing outputs: sleep forces safe-off with protection
         for (k = 0; k < 3; k = k + 1) begin
            HS_PD_EN[k] <= CHIP_SLEEP || regs[8*(5+k)+1];
            HS_PROTECT[k] <= CHIP_SLEEP || regs[8*(5+k)+1 -: 2] == `PDRC_HS_PD_PROT
               || (r_func[`PDRC_BIT_DIST_PD] && regs[8*(5+k)+1 -: 2] != `PDRC_HS_PD_NOPROT);
         end
         // Secondary outputs off in sleep or by their own bit
         for (k = 0; k < 2; k = k + 1) begin
            SEC_PD[k] <= CHIP_SLEEP || regs[8*(8+k)];
            SEC_CMOS[k] <= regs[8*(8+k)+`PDRC_OUT_FMT_BIT];
         end
         FINE_DELAY <= r_fine[`PDRC_FINE_HI:`PDRC_FINE_LO];
         RAMP_CODE <= r_fs[`PDRC_RAMP_HI:`PDRC_RAMP_LO];
         CAP_SELECT <= r_fs[`PDRC_CAPS_HI:`PDRC_CAPS_LO];
         RAMP_CURRENT_UA <= pdrc_ramp_ua(r_fs[`PDRC_RAMP_HI:`PDRC_RAMP_LO]);
         BLOCK_PD <= r_blk[2:0];
      end
   end

   // Ramp current in microamps, 200 per step plus one
   function [10:0] pdrc_ramp_ua;
      input [2:0] code;
      begin
         pdrc_ramp_ua = (11'h000 + code + 11'h001) * `PDRC_RAMP_STEP_UA;
      end
   endfunction
   // A sync request after wake is the controller's duty; SYNC_HOLD carries it
endmodule // pdrc_top
`default_nettype wire
